// file: rtl/iem_pkg.sv
// Package: offsets, reset values, field positions and carriers for the interrupt enable mask
package iem_pkg;
    localparam int IEM_ADDR_W = 8;
    localparam int IEM_DATA_W = 8;
    localparam int IEM_NUM_SRC = 16;
    localparam logic [7:0] IEM_OFS_ENABLE_LOW = 8'h43;
    localparam logic [7:0] IEM_OFS_ENABLE_MID = 8'h44;
    localparam logic [7:0] IEM_RST_ENABLE_LOW = 8'h00;
    localparam logic [7:0] IEM_RST_ENABLE_MID = 8'h00;
    localparam int IEM_BIT_REF_FIRST_LOW = 0;
    localparam int IEM_BIT_REF_FIRST_MID = 0;
    localparam int IEM_BIT_REF_FOURTEEN = 5;
    localparam int IEM_BIT_MAIN_REF_FAILED = 6;
    localparam int IEM_BIT_OPERATING_MODE = 7;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [IEM_ADDR_W-1:0] addr;
        logic [IEM_DATA_W-1:0] wdata;
    } iem_req_s;

    // Event word: [7:0] inputs 1..8, [12:8] inputs 9..13, [13] input 14,
    // [14] main reference failure, [15] operating mode change
    typedef logic [IEM_NUM_SRC-1:0] iem_event_t;
endpackage : iem_pkg

// file: rtl/iem_mask_reg.sv
// One byte-wide read/write mask register with reset value
`timescale 1ns/1ps
module iem_mask_reg
    import iem_pkg::*;
#(
    parameter logic [IEM_DATA_W-1:0] RESET_VALUE = '0
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [IEM_DATA_W-1:0] wdata,
    output logic [IEM_DATA_W-1:0] value
);
    logic [IEM_DATA_W-1:0] value_reg;
    logic [IEM_DATA_W-1:0] value_next;

    always_comb begin
        value_next = value_reg;
        if (wr_en) begin
            value_next = wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            value_reg <= RESET_VALUE;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;
endmodule : iem_mask_reg

// file: rtl/iem_interrupt_enable_mask_low.sv
// Interrupt enable mask, bits [15:0]: two byte registers gating pending events
// ----------------------------------------------------------------------------
// Notes on behaviour
// - The register at 0x43 holds mask bits 7..0, bit k enabling reference input k+1.
// - A clear mask bit keeps that input's events from raising the interrupt.
// - A set mask bit lets that input's events raise the interrupt.
// - Both mask registers are read/write and reset to zero, all sources disabled.
// - The register at 0x44 holds mask bits 15..8, bit 7 mode change, bit 5 input 14.
// - Bit 6 at 0x44 gates the main reference failure event.
// - Bits 4..0 at 0x44 enable reference inputs 13 down to 9.
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
module iem_interrupt_enable_mask_low
    import iem_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire iem_req_s reg_req,
    output logic [IEM_DATA_W-1:0] reg_rdata,
    output logic reg_hit,
    input wire iem_event_t event_pending,
    output iem_event_t event_enabled,
    output logic irq_request
);
    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    function automatic logic iem_hit(input logic [IEM_ADDR_W-1:0] a,
                                     input logic [IEM_ADDR_W-1:0] ofs);
        iem_hit = (a == ofs);
    endfunction : iem_hit

    logic wr_low;
    logic wr_mid;
    logic [IEM_DATA_W-1:0] mask_low;
    logic [IEM_DATA_W-1:0] mask_mid;

    assign wr_low = reg_req.wr && iem_hit(reg_req.addr, IEM_OFS_ENABLE_LOW);
    assign wr_mid = reg_req.wr && iem_hit(reg_req.addr, IEM_OFS_ENABLE_MID);

    // ------------------------------------------------------------------------
    // Mask registers
    // ------------------------------------------------------------------------
    iem_mask_reg #(
        .RESET_VALUE(IEM_RST_ENABLE_LOW)
    ) u_enable_low (
        .core_clk(core_clk),
        .rst(rst),
        .wr_en(wr_low),
        .wdata(reg_req.wdata),
        .value(mask_low)
    );

    iem_mask_reg #(
        .RESET_VALUE(IEM_RST_ENABLE_MID)
    ) u_enable_mid (
        .core_clk(core_clk),
        .rst(rst),
        .wr_en(wr_mid),
        .wdata(reg_req.wdata),
        .value(mask_mid)
    );

    // ------------------------------------------------------------------------
    // Read path, registered; unmapped reads return zero
    // ------------------------------------------------------------------------
    logic [IEM_DATA_W-1:0] rdata_reg;
    logic [IEM_DATA_W-1:0] rdata_next;
    logic hit_reg;
    logic hit_next;

    always_comb begin
        rdata_next = rdata_reg;
        hit_next = 1'b0;
        if (reg_req.rd) begin
            hit_next = 1'b1;
            if (iem_hit(reg_req.addr, IEM_OFS_ENABLE_LOW)) begin
                rdata_next = mask_low;
            end else if (iem_hit(reg_req.addr, IEM_OFS_ENABLE_MID)) begin
                rdata_next = mask_mid;
            end else begin
                rdata_next = 8'h00;
                hit_next = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
            hit_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            hit_reg <= hit_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_hit = hit_reg;

    // ------------------------------------------------------------------------
    // Gating: the 16 mask bits line up one to one with the event word
    // ------------------------------------------------------------------------
    iem_event_t mask_all;
    iem_event_t enabled_reg;
    iem_event_t enabled_next;
    logic irq_reg;
    logic irq_next;

    assign mask_all = {mask_mid, mask_low};

    // Per-source gate; events still arrive at the status side unmasked
    genvar g;
    generate
        for (g = 0; g < IEM_NUM_SRC; g++) begin : g_gate
            assign enabled_next[g] = event_pending[g] & mask_all[g];
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Source groups of the gated event word
    // ------------------------------------------------------------------------
    localparam int MID_REF_LSB = IEM_DATA_W + IEM_BIT_REF_FIRST_MID;
    localparam int MID_REF_CNT = IEM_BIT_REF_FOURTEEN - IEM_BIT_REF_FIRST_MID;

    logic [IEM_DATA_W-1:0] ref_low_gate;
    logic [MID_REF_CNT-1:0] ref_mid_gate;
    logic ref_fourteen_gate;
    logic main_ref_gate;
    logic mode_change_gate;

    assign ref_low_gate = enabled_next[IEM_BIT_REF_FIRST_LOW +: IEM_DATA_W];
    assign ref_mid_gate = enabled_next[MID_REF_LSB +: MID_REF_CNT];
    assign ref_fourteen_gate = enabled_next[IEM_DATA_W + IEM_BIT_REF_FOURTEEN];
    assign main_ref_gate = enabled_next[IEM_DATA_W + IEM_BIT_MAIN_REF_FAILED];
    assign mode_change_gate = enabled_next[IEM_DATA_W + IEM_BIT_OPERATING_MODE];

    // Registered so the output is glitch free; costs one cycle of latency
    always_comb begin
        irq_next = (|ref_low_gate) || (|ref_mid_gate) || ref_fourteen_gate
            || main_ref_gate || mode_change_gate;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            enabled_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            enabled_reg <= enabled_next;
            irq_reg <= irq_next;
        end
    end

    assign event_enabled = enabled_reg;
    assign irq_request = irq_reg;
endmodule : iem_interrupt_enable_mask_low

// file: test/iem_mask_props.sv
// Port checker of the interrupt enable mask
`timescale 1ns/1ps
module iem_mask_props
    import iem_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire iem_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit,
    input wire iem_event_t event_pending,
    input wire iem_event_t event_enabled,
    input wire logic irq_request
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    wire logic mapped = reg_req.addr inside {8'h43, 8'h44};
    wire logic [7:0] w = reg_req.wdata;
    sequence s_wr_rd;
        reg_req.wr && mapped ##1 reg_req.rd && !reg_req.wr && $stable(reg_req.addr);
    endsequence
    AST_BACK: assert property (s_wr_rd |=> reg_rdata == $past(w, 2)) else $error("back");
    AST_HIT: assert property (reg_hit == $past(reg_req.rd && mapped)) else $error("hit");
    AST_OFF: assert property (reg_req.rd && !mapped |=> !reg_hit && !reg_rdata)
        else $error("off");
    AST_HOLD: assert property (!reg_req.rd |=> $stable(reg_rdata)) else $error("hold");
    AST_IRQ: assert property (irq_request == |event_enabled) else $error("irq");
    AST_SRC: assert property (irq_request |-> $past(|event_pending)) else $error("src");
    AST_GATE: assert property (!(event_enabled & ~$past(event_pending))) else $error("gate");
    AST_MID: assert property (reg_req.wr && reg_req.addr == 8'h44 && w == 8'hFF
        |=> ##1 event_enabled[15:8] == $past(event_pending[15:8])) else $error("mid");
    AST_LOW: assert property (reg_req.wr && reg_req.addr == 8'h43 && w == 8'h00
        |=> ##1 event_enabled[7:0] == 8'h00) else $error("low");
endmodule : iem_mask_props
bind iem_interrupt_enable_mask_low iem_mask_props iem_mask_props_inst (.core_clk, .rst,
    .reg_req, .reg_rdata, .reg_hit, .event_pending, .event_enabled, .irq_request);

// file: test/tb_top.sv
// Self-checking bench of the interrupt enable mask
`timescale 1ns/1ps
module tb_top
    import iem_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    iem_req_s reg_req = '0;
    iem_event_t event_pending = '1;
    iem_event_t event_enabled, e;
    logic [7:0] reg_rdata;
    logic reg_hit, irq_request;
    int fails = 0;
    int tests_run = 0;
    // Low mask, mid mask, pending events, expected enabled events
    logic [47:0] rows [10] = '{48'h0100_0001_0001, 48'h8000_FFFF_0080,
        48'h0020_FFFF_2000, 48'h0040_FFFF_4000, 48'h0080_FFFF_8000,
        48'h001F_FFFF_1F00, 48'hFEBF_4001_0000, 48'h55AA_FFFF_AA55,
        48'hFFFF_0000_0000, 48'h0000_FFFF_0000};
    always #5 core_clk = ~core_clk;
    iem_interrupt_enable_mask_low iem_interrupt_enable_mask_low_inst (.core_clk, .rst,
        .reg_req, .reg_rdata, .reg_hit, .event_pending, .event_enabled, .irq_request);
    task chk(input logic [15:0] s, input logic [15:0] x, input string n);
        tests_run++;
        if (s !== x) begin
            fails++;
            $display("unexpected %s exp %h seen %h", n, x, s);
        end
    endtask : chk
    task go(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d);
        reg_req = {k, a, d};
        @(negedge core_clk);
    endtask : go
    task wrap_up;
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (16) @(negedge core_clk);
        chk(16'({irq_request, reg_hit, reg_rdata}), 16'h0000, "in reset");
        rst = 1'b0;
        go(2'h1, 8'h43, 8'h00);
        chk(16'({reg_hit, reg_rdata}), 16'h0100, "reset");
        chk(event_enabled, 16'h0000, "reset enabled");
        $display("reset done");
        foreach (rows[i]) begin
            e = rows[i][15:0];
            go(2'h2, 8'h44, rows[i][39:32]);
            go(2'h2, 8'h43, rows[i][47:40]);
            event_pending = rows[i][31:16];
            go(2'h1, 8'h43, 8'h00);
            chk(16'(reg_rdata), 16'(rows[i][47:40]), "low");
            chk(event_enabled, e, "enabled");
            chk(16'(irq_request), 16'(e != 16'h0000), "irq");
            go(2'h1, 8'h44, 8'h00);
            chk(16'(reg_rdata), 16'(rows[i][39:32]), "mid");
        end
        $display("rows done");
        go(2'h2, 8'h43, 8'h01);
        chk(16'(irq_request), 16'h0000, "irq early");
        go(2'h1, 8'h43, 8'h00);
        chk(16'({irq_request, reg_rdata}), 16'h0101, "irq next");
        go(2'h2, 8'h44, 8'hAA);
        go(2'h1, 8'h44, 8'h00);
        chk(16'({reg_hit, reg_rdata}), 16'h01AA, "mid back");
        go(2'h1, 8'h45, 8'h00);
        chk(16'({reg_hit, reg_rdata}), 16'h0000, "unmapped");
        go(2'h1, 8'h44, 8'h00);
        rst = 1'b1;
        go(2'h0, 8'h00, 8'h00);
        chk(16'({irq_request, reg_hit, reg_rdata}), 16'h0000, "mid in reset");
        rst = 1'b0;
        go(2'h1, 8'h44, 8'h00);
        chk(16'({irq_request, reg_rdata}), 16'h0000, "mid reset");
        $display("edges done");
        wrap_up();
    end
endmodule : tb_top
